// *** rtl/qec_decode.sv ***
`timescale 1ns/10ps
module qec_decode (
  qec_pins_if.dec pins // levels and edges in, steps out
);

  // edge on one phase counts up when its new level equals the other phase
  function automatic logic step_is_up(input logic new_lvl, input logic other_lvl);
    step_is_up = (new_lvl == other_lvl);
  endfunction

  logic a_edge;
  logic b_edge;

  assign a_edge = pins.rise[qec_pkg::PIN_A] | pins.fall[qec_pkg::PIN_A];
  assign b_edge = pins.rise[qec_pkg::PIN_B] | pins.fall[qec_pkg::PIN_B];

  always_comb
  begin
    pins.step_up = 1'b0;
    pins.step_dn = 1'b0;
    // both phases moving together carries no direction, so it is dropped
    if (a_edge && !b_edge)
    begin
      pins.step_up = step_is_up(pins.lvl[qec_pkg::PIN_A], pins.lvl[qec_pkg::PIN_B]);
      pins.step_dn = ~step_is_up(pins.lvl[qec_pkg::PIN_A], pins.lvl[qec_pkg::PIN_B]);
    end
    else if (b_edge && !a_edge)
    begin
      pins.step_up = step_is_up(pins.lvl[qec_pkg::PIN_B], pins.lvl[qec_pkg::PIN_A]);
      pins.step_dn = ~step_is_up(pins.lvl[qec_pkg::PIN_B], pins.lvl[qec_pkg::PIN_A]);
    end
  end

endmodule

// *** rtl/qec_pins_if.sv ***
`timescale 1ns/10ps
interface qec_pins_if;
  logic [qec_pkg::PIN_N-1:0] lvl;
  logic [qec_pkg::PIN_N-1:0] rise;
  logic [qec_pkg::PIN_N-1:0] fall;
  logic                      step_up;
  logic                      step_dn;

  modport sync (output lvl, output rise, output fall);
  modport dec  (input lvl, input rise, input fall, output step_up, output step_dn);
  modport core (input lvl, input rise, input fall, input step_up, input step_dn);
endinterface

// *** rtl/qec_pkg.sv ***
package qec_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_MASK        = 8'h08;
  localparam logic [7:0] OFS_POSITION    = 8'h0C;
  localparam logic [7:0] OFS_INDEX_CAP   = 8'h10;
  localparam logic [7:0] OFS_PERIOD_CAP  = 8'h14;
  localparam logic [7:0] OFS_PERIOD_CMP  = 8'h18;
  localparam logic [7:0] OFS_PERIOD_CNT  = 8'h1C;
  localparam logic [7:0] OFS_INTVL_CAP   = 8'h20;
  localparam logic [7:0] OFS_INTVL_BUF   = 8'h24;

  // control fields
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_BUF_EN  = 1;

  // status / mask fields
  localparam int ST_INDEX     = 0;
  localparam int ST_PERIODIC  = 1;
  localparam int ST_INTERVAL  = 2;
  localparam int ST_OVERFLOW  = 3;
  localparam int ST_UNDERFLOW = 4;
  localparam int ST_W         = 5;

  localparam int CNT_W_DEF    = 16;

  // period timer: 1 ms at a 25 ns clock
  localparam int PERIOD_TIME_NS = 1_000_000;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int PERIOD_CYCLES  = PERIOD_TIME_NS / CLK_PERIOD_NS;

  // pin order on the synchroniser
  localparam int PIN_A   = 0;
  localparam int PIN_B   = 1;
  localparam int PIN_IDX = 2;
  localparam int PIN_N   = 3;

endpackage

// *** rtl/qec_sync.sv ***
`timescale 1ns/10ps
module qec_sync (
  input  wire logic                      ref_clk, // clock
  input  wire logic                      rst,     // sync reset, high
  input  wire logic [qec_pkg::PIN_N-1:0] pin_in,  // raw encoder pins
  qec_pins_if.sync                       pins     // filtered levels and edges
);

  typedef struct packed {
    logic [qec_pkg::PIN_N-1:0] s1;
    logic [qec_pkg::PIN_N-1:0] s2;
    logic [qec_pkg::PIN_N-1:0] s3;
    logic [qec_pkg::PIN_N-1:0] lvl;
    logic [qec_pkg::PIN_N-1:0] rise;
    logic [qec_pkg::PIN_N-1:0] fall;
  } qec_sync_t;

  qec_sync_t q;
  qec_sync_t d;

  always_comb
  begin
    d      = q;
    d.s1   = pin_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = '0;
    d.fall = '0;
    for (int i = 0; i < qec_pkg::PIN_N; i++)
    begin
      // a change counts only once stages two and three agree
      if ((q.s2[i] == q.s3[i]) && (q.s3[i] != q.lvl[i]))
      begin
        d.lvl[i]  = q.s3[i];
        d.rise[i] = q.s3[i];
        d.fall[i] = ~q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign pins.lvl  = q.lvl;
  assign pins.rise = q.rise;
  assign pins.fall = q.fall;

endmodule

// *** rtl/qec_top.sv ***
// Summary of operation
// - sixteen bit counters with capture and compare registers
// - position counts up or down from phases
// - only the first of four counting variants
// - direction from edge and level of other phase
// - every phase edge moves count by one; the code drops edges on both phases in the same cycle
// - detect phase difference, count on each transition; the code does not count a change of both phases at once
// - index rise captures position, raises index flag
// - index rise clears position to zero
// - period match captures position, raises periodic flag
// - period timer clears on compare match, 1 ms
// - period timer counts every clock, undivided
// - each step captures period timer, raises interval flag
// - buffer mode keeps the previous interval capture
// - separate overflow and underflow flags
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module qec_top #(
  parameter int CNT_W         = qec_pkg::CNT_W_DEF,    // counter width
  parameter int PERIOD_CYCLES = qec_pkg::PERIOD_CYCLES // clocks per period
) (
  input  wire logic        ref_clk,        // 40 MHz clock
  input  wire logic        rst,            // sync reset, high
  input  wire logic        enc_phase_a_in, // encoder phase a pin
  input  wire logic        enc_phase_b_in, // encoder phase b pin
  input  wire logic        enc_index_in,   // encoder index pin
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             irq             // level interrupt, high
);

  initial
  begin
    if (CNT_W < 2 || CNT_W > 32)
      $error("CNT_W out of range");
    if (PERIOD_CYCLES < 1 || PERIOD_CYCLES > (2 ** CNT_W))
      $error("PERIOD_CYCLES does not fit the period timer");
  end

  localparam logic [CNT_W-1:0] CNT_MAX   = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CMP_RESET = CNT_W'(PERIOD_CYCLES - 1);

  typedef struct packed {
    logic                         run;
    logic                         buf_en;
    logic [qec_pkg::ST_W-1:0]     status;
    logic [qec_pkg::ST_W-1:0]     mask;
    logic [CNT_W-1:0]             enc_position_counter;
    logic [CNT_W-1:0]             index_capture_reg;
    logic [CNT_W-1:0]             periodic_capture_reg;
    logic [CNT_W-1:0]             period_compare_reg;
    logic [CNT_W-1:0]             period_timer_counter;
    logic [CNT_W-1:0]             interval_capture_reg;
    logic [CNT_W-1:0]             interval_buffer_reg;
    logic [31:0]                  rdata;
    logic                         err;
  } qec_state_t;

  qec_state_t q;
  qec_state_t d;

  qec_pins_if pins_if ();

  qec_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  ({enc_index_in, enc_phase_b_in, enc_phase_a_in}),
    .pins    (pins_if.sync)
  );

  qec_decode u_decode (
    .pins (pins_if.dec)
  );

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      qec_pkg::OFS_CTRL,       qec_pkg::OFS_STATUS,     qec_pkg::OFS_MASK,
      qec_pkg::OFS_POSITION,   qec_pkg::OFS_INDEX_CAP,  qec_pkg::OFS_PERIOD_CAP,
      qec_pkg::OFS_PERIOD_CMP, qec_pkg::OFS_PERIOD_CNT, qec_pkg::OFS_INTVL_CAP,
      qec_pkg::OFS_INTVL_BUF:
        addr_mapped = 1'b1;
      default:
        addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    widen = 32'(v);
  endfunction

  logic                     wr_en;
  logic                     setup;
  logic                     match;
  logic                     step;
  logic [qec_pkg::ST_W-1:0] ev;
  logic [qec_pkg::ST_W-1:0] clr;
  logic [31:0]              rmux;

  assign wr_en = psel & penable & pwrite & addr_mapped(paddr);
  assign setup = psel & ~penable;
  assign match = q.run && (q.period_timer_counter == q.period_compare_reg);
  assign step  = q.run & (pins_if.step_up | pins_if.step_dn);

  always_comb
  begin
    rmux = 32'h0000_0000;
    case (paddr)
      qec_pkg::OFS_CTRL:
      begin
        rmux[qec_pkg::CTRL_RUN]    = q.run;
        rmux[qec_pkg::CTRL_BUF_EN] = q.buf_en;
      end
      qec_pkg::OFS_STATUS:     rmux = 32'(q.status);
      qec_pkg::OFS_MASK:       rmux = 32'(q.mask);
      qec_pkg::OFS_POSITION:   rmux = widen(q.enc_position_counter);
      qec_pkg::OFS_INDEX_CAP:  rmux = widen(q.index_capture_reg);
      qec_pkg::OFS_PERIOD_CAP: rmux = widen(q.periodic_capture_reg);
      qec_pkg::OFS_PERIOD_CMP: rmux = widen(q.period_compare_reg);
      qec_pkg::OFS_PERIOD_CNT: rmux = widen(q.period_timer_counter);
      qec_pkg::OFS_INTVL_CAP:  rmux = widen(q.interval_capture_reg);
      qec_pkg::OFS_INTVL_BUF:  rmux = widen(q.interval_buffer_reg);
      default:                 rmux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    d   = q;
    ev  = '0;
    clr = '0;

    // read data and error are sampled in the setup phase, so they come from flops
    if (setup)
    begin
      d.rdata = pwrite ? 32'h0000_0000 : rmux;
      d.err   = ~addr_mapped(paddr);
    end

    // software writes first; hardware events below override the same cycle
    if (wr_en)
    begin
      case (paddr)
        qec_pkg::OFS_CTRL:
        begin
          d.run    = pwdata[qec_pkg::CTRL_RUN];
          d.buf_en = pwdata[qec_pkg::CTRL_BUF_EN];
        end
        qec_pkg::OFS_STATUS:     clr = pwdata[qec_pkg::ST_W-1:0];
        qec_pkg::OFS_MASK:       d.mask = pwdata[qec_pkg::ST_W-1:0];
        qec_pkg::OFS_POSITION:   d.enc_position_counter = pwdata[CNT_W-1:0];
        qec_pkg::OFS_PERIOD_CMP: d.period_compare_reg = pwdata[CNT_W-1:0];
        default:                 d.err = q.err;
      endcase
    end

    // period timer, one count per clock
    if (q.run)
    begin
      if (match)
        d.period_timer_counter = '0;
      else
        d.period_timer_counter = CNT_W'(q.period_timer_counter + 1'b1);
    end

    if (match)
    begin
      d.periodic_capture_reg   = q.enc_position_counter;
      ev[qec_pkg::ST_PERIODIC] = 1'b1;
    end

    if (step)
    begin
      d.interval_capture_reg   = q.period_timer_counter;
      ev[qec_pkg::ST_INTERVAL] = 1'b1;
      if (q.buf_en)
        d.interval_buffer_reg  = q.interval_capture_reg;
      if (pins_if.step_up)
      begin
        d.enc_position_counter = CNT_W'(q.enc_position_counter + 1'b1);
        if (q.enc_position_counter == CNT_MAX)
          ev[qec_pkg::ST_OVERFLOW] = 1'b1;
      end
      else
      begin
        d.enc_position_counter = CNT_W'(q.enc_position_counter - 1'b1);
        if (q.enc_position_counter == '0)
          ev[qec_pkg::ST_UNDERFLOW] = 1'b1;
      end
    end

    // index wins over a step in the same cycle; that step is not counted
    if (q.run && pins_if.rise[qec_pkg::PIN_IDX])
    begin
      d.index_capture_reg    = q.enc_position_counter;
      ev[qec_pkg::ST_INDEX]  = 1'b1;
      d.enc_position_counter = '0;
    end

    // a new event survives a clear written in the same cycle
    d.status = (q.status & ~clr) | ev;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      q                    <= '0;
      q.period_compare_reg <= CMP_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // zero wait state slave
  assign pready  = 1'b1;
  assign prdata  = q.rdata;
  assign pslverr = q.err & psel & penable;
  assign irq     = |(q.status & q.mask);

endmodule

// *** test/qec_enc_model.sv ***
`timescale 1ns/10ps
module qec_enc_model (
  input  wire logic ref_clk, // pacing clock
  output logic      pha,     // phase a
  output logic      phb,     // phase b
  output logic      idx      // index
);
  initial
  begin
    pha = 1'b0;
    phb = 1'b0;
    idx = 1'b0;
  end
  // edges spaced past the input filter so none merge
  task automatic edge_on(input logic on_b);
    @(posedge ref_clk);
    if (on_b) phb <= ~phb;
    else pha <= ~pha;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic index_pulse();
    @(posedge ref_clk);
    idx <= 1'b1;
    repeat (8) @(posedge ref_clk);
    idx <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// *** test/qec_top_properties.sv ***
`timescale 1ns/10ps
module qec_top_properties (
  input wire logic        ref_clk,        // clock
  input wire logic        rst,            // sync reset, high
  input wire logic        enc_phase_a_in, // phase a pin
  input wire logic        enc_phase_b_in, // phase b pin
  input wire logic        enc_index_in,   // index pin
  input wire logic        psel,           // apb select
  input wire logic        penable,        // apb enable
  input wire logic        pwrite,         // apb direction
  input wire logic [7:0]  paddr,          // apb address
  input wire logic [31:0] pwdata,         // apb write data
  input wire logic [31:0] prdata,         // apb read data
  input wire logic        pready,         // apb ready
  input wire logic        pslverr,        // apb error
  input wire logic        irq             // interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_setup_bad; psel && !penable && !pwrite && paddr > 8'h24; endsequence
  sequence s_access; psel && penable; endsequence
  chk_ready_const: assert property (pready)
    else $error("pready dropped");
  chk_err_setup: assert property (psel && !penable |-> !pslverr)
    else $error("error flagged in setup");
  chk_err_idle: assert property (!psel |-> !pslverr)
    else $error("error flagged while idle");
  chk_bad_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access not refused");
  chk_good_ok: assert property (psel && penable && paddr <= 8'h24 && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("mapped access refused");
  chk_bad_zero: assert property (s_setup_bad ##1 s_access |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  chk_irq_fall: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("interrupt dropped without a write");
  chk_rst_quiet: assert property ($fell(rst) |-> !irq && prdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
endmodule
bind qec_top qec_top_properties u_chk (.ref_clk(ref_clk), .rst(rst),
  .enc_phase_a_in(enc_phase_a_in), .enc_phase_b_in(enc_phase_b_in),
  .enc_index_in(enc_index_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// *** test/quadrature_encoder_counter_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module quadrature_encoder_counter_tb;
  localparam int PC = 20;
  logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000, prdata, rd, icap, c0;
  logic        pready, pslverr, irq, pha, phb, idx, err, ov, un;
  logic        ea = 1'b0, eb = 1'b0;
  logic [15:0] pos;
  int          n_fail = 0, n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  qec_top #(.CNT_W(16), .PERIOD_CYCLES(PC)) dut (.ref_clk(ref_clk), .rst(rst),
    .enc_phase_a_in(pha), .enc_phase_b_in(phb), .enc_index_in(idx), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  qec_enc_model enc (.ref_clk(ref_clk), .pha(pha), .phb(phb), .idx(idx));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(nm, exp, rd)
  endtask
  // expectation: up when the moved phase now equals the other
  task automatic step(input logic on_b);
    if (on_b) eb = ~eb;
    else ea = ~ea;
    ov = (ea == eb) && pos == 16'hFFFF;
    un = (ea != eb) && pos == 16'h0000;
    pos = (ea == eb) ? pos + 16'h0001 : pos - 16'h0001;
    enc.edge_on(on_b);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rchk("ctrl rst", qec_pkg::OFS_CTRL, 32'h0000_0000);
    rchk("cmp rst", qec_pkg::OFS_PERIOD_CMP, PC - 1);
    xfer(1'b1, qec_pkg::OFS_MASK, 32'h0000_001F);
    xfer(1'b1, qec_pkg::OFS_CTRL, 32'h0000_0003);
    pos = 16'h0000;
    icap = 32'h0000_0000;
    // a,b,a,b then b,a,b,a: all eight edge kinds, wrapping at both ends
    for (int i = 0; i < 8; i++)
    begin
      step(logic'(i[0] ^ i[2]));
      rchk("position", qec_pkg::OFS_POSITION, {16'h0000, pos});
      rchk("intvl buf", qec_pkg::OFS_INTVL_BUF, icap);
      xfer(1'b0, qec_pkg::OFS_INTVL_CAP, 32'h0000_0000);
      icap = rd;
      `CHK("intvl range", 1'b1, rd < PC)
      xfer(1'b0, qec_pkg::OFS_STATUS, 32'h0000_0000);
      `CHK("step flags", {un, ov, 1'b1}, rd[4:2])
      xfer(1'b1, qec_pkg::OFS_STATUS, 32'h0000_001C);
    end
    xfer(1'b1, qec_pkg::OFS_CTRL, 32'h0000_0001);
    xfer(1'b0, qec_pkg::OFS_INTVL_BUF, 32'h0000_0000);
    c0 = rd;
    step(1'b0);
    rchk("buf off", qec_pkg::OFS_INTVL_BUF, c0);
    rchk("pos nobuf", qec_pkg::OFS_POSITION, {16'h0000, pos});
    xfer(1'b1, qec_pkg::OFS_STATUS, 32'h0000_001F);
    xfer(1'b1, qec_pkg::OFS_MASK, 32'h0000_0001);
    @(negedge ref_clk);
    `CHK("irq masked", 1'b0, irq)
    xfer(1'b1, qec_pkg::OFS_POSITION, 32'h0000_1234);
    enc.index_pulse();
    `CHK("irq index", 1'b1, irq)
    rchk("index cap", qec_pkg::OFS_INDEX_CAP, 32'h0000_1234);
    rchk("index clr", qec_pkg::OFS_POSITION, 32'h0000_0000);
    xfer(1'b1, qec_pkg::OFS_STATUS, 32'h0000_0001);
    @(negedge ref_clk);
    `CHK("irq clear", 1'b0, irq)
    xfer(1'b1, qec_pkg::OFS_PERIOD_CMP, 32'h0000_0063);
    xfer(1'b1, qec_pkg::OFS_POSITION, 32'h0000_00AB);
    repeat (110) @(posedge ref_clk);
    rchk("period cap", qec_pkg::OFS_PERIOD_CAP, 32'h0000_00AB);
    xfer(1'b0, qec_pkg::OFS_PERIOD_CNT, 32'h0000_0000);
    c0 = rd;
    xfer(1'b0, qec_pkg::OFS_PERIOD_CNT, 32'h0000_0000);
    `CHK("timer rate", (c0 + 32'h0000_0003) % 32'h0000_0064, rd)
    xfer(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped rd", 32'h0000_0000, rd)
    `CHK("unmapped err", 1'b1, err)
    xfer(1'b1, qec_pkg::OFS_INDEX_CAP, 32'hFFFF_FFFF);
    rchk("ro write", qec_pkg::OFS_INDEX_CAP, 32'h0000_1234);
    give_verdict();
  end
endmodule
